// *** rtl/dpr_cfg.svh ***
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DPR_OFS_CTRL   8'h00
`define DPR_OFS_KP     8'h04
`define DPR_OFS_TI     8'h08
`define DPR_OFS_TD     8'h0C
`define DPR_OFS_SDCAP  8'h10
`define DPR_OFS_PDCAP  8'h14
`define DPR_OFS_TAU    8'h18
`define DPR_OFS_ENTRY  8'h1C
`define DPR_OFS_FMIN   8'h20
`define DPR_OFS_FMAX   8'h24
`define DPR_OFS_VSTART 8'h28
`define DPR_OFS_U1     8'h2C
`define DPR_OFS_U2     8'h30
`define DPR_OFS_U3     8'h34
`define DPR_OFS_F1     8'h38
`define DPR_OFS_F2     8'h3C
`define DPR_OFS_F3     8'h40
`define DPR_OFS_STAT   8'h44
`define DPR_OFS_VOLT   8'h48
`define DPR_NREG_RW    17
// ****************************************************************
// Control fields
// ****************************************************************
`define DPR_CTL_CFG_LSB 0
`define DPR_CTL_INV     4
`define DPR_CTL_AW      5
`define DPR_CTL_RUN     6
`define DPR_CTL_TQ_LSB  8
`define DPR_CFG_SPEED   4'h1
`define DPR_CFG_PROC    4'h3
`define DPR_TQ_SPECIAL  4'h8
// ****************************************************************
// Reset values and ranges (freq 0.1 Hz, volt 0.1 V, gain 0.001,
// Ti 0.01 ms, Td ms, cap 0.1, tau ms)
// ****************************************************************
`define DPR_RST_CTRL   32'h0000_0021
`define DPR_KP_MAX     32'h0000_03E8
`define DPR_RST_KP     32'h0000_000A
`define DPR_TI_MIN     32'h0000_07D0
`define DPR_TI_OFF     32'h0001_86A0
`define DPR_RST_TI     32'h0000_2710
`define DPR_TD_MAX     32'h0000_2710
`define DPR_CAP_MIN    32'h0000_0032
`define DPR_CAP_MAX    32'h0000_01F4
`define DPR_TAU_MIN    32'h0000_0014
`define DPR_TAU_MAX    32'h0000_01F4
`define DPR_RST_TAU    32'h0000_0064
`define DPR_PROC_TAU   32'h0000_0014
`define DPR_RST_FMIN   32'h0000_0000
`define DPR_RST_FMAX   32'h0000_01F4
`define DPR_VOLT_MAX   32'h0000_2706
`define DPR_RST_VRATED 32'h0000_0FA0
`define DPR_RST_FRATED 32'h0000_01F4
`define DPR_FREQ_TOP   32'h0000_2710
`define DPR_RAMP_STEP  16'h0001
// ****************************************************************
// Timing
// ****************************************************************
`define DPR_TS_US      1000
`define DPR_CLK_MHZ    125
`define DPR_SAMPLE_CYC (`DPR_TS_US * `DPR_CLK_MHZ)
`endif

// *** rtl/dpr_pkg.sv ***
package dpr_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_LOOP = 2'b10
  } dpr_state_e;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } dpr_aph_s;
  typedef struct packed {
    logic [15:0] ref_val;
    logic [15:0] fb_val;
  } dpr_meas_s;
  typedef logic [31:0] dpr_word_t;
endpackage

// *** rtl/dpr_regulator.sv ***
`include "dpr_cfg.svh"
// Behaviour
// R1 - Separate derivative caps for speed and process
// R2 - Feedback lowpass, tau 20 to 500 ms
// R3 - Normal: ref above feedback raises speed
// R4 - Inverse: ref above feedback lowers speed
// R5 - Anti-windup reloads integrator with output frequency
// R6 - Open-loop run-up to entry frequency first
// R7 - Speed settings only in speed configuration
// R8 - P gain 0.000 to 1.000, default 0.010
// R9 - Ti 20 to 999.99 ms, 1000 off
// R10 - Derivative acts on error change, 0 off
// R11 - Speed derivative cap 5.0 to 50.0
// R12 - Special curve: four volts, three freqs
// R13 - Curve volts 0 to 999.0 V
// R14 - First curve freq between 0 and second
// R15 - Third curve freq between second and 1000 Hz
// R16 - Process derivative cap 5.0 to 50.0
// R17 - Recursive filter, coefficient from tau
// R18 - Linear interpolation, hold last point
module dpr_regulator #(
  parameter int SAMPLE_CYC = `DPR_SAMPLE_CYC
) (
  // Clock, reset, enable
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  // Reference and feedback from on-chip logic
  input  wire dpr_pkg::dpr_meas_s meas,
  // Limit pins from inverter stage
  input  wire logic               cur_lim_pin,
  input  wire logic               volt_lim_pin,
  // Commands to inverter
  output logic [15:0]             freq_cmd,
  output logic [15:0]             volt_cmd,
  output logic                    running
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************************************
  // Register file
  // ****************************************************************
  dpr_pkg::dpr_word_t regs_q [`DPR_NREG_RW];
  dpr_pkg::dpr_word_t regs_d [`DPR_NREG_RW];
  dpr_pkg::dpr_aph_s  aph_q, aph_d;
  logic [31:0]        rdata_q, rdata_d;
  logic [4:0]         wix, rix;
  dpr_pkg::dpr_state_e state_q, state_d;
  logic [15:0]        freq_q, freq_d, volt_q, volt_d;
  logic               lim_q, lim_d;

  function automatic logic [31:0] clampv(input logic [31:0] v,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [31:0] rst_val(input int i);
    case (i)
      0:       rst_val = `DPR_RST_CTRL;
      1:       rst_val = `DPR_RST_KP;
      2:       rst_val = `DPR_RST_TI;
      4, 5:    rst_val = `DPR_CAP_MIN;
      6:       rst_val = `DPR_RST_TAU;
      8, 7:    rst_val = `DPR_RST_FMIN;
      9:       rst_val = `DPR_RST_FMAX;
      11, 12, 13: rst_val = `DPR_RST_VRATED;
      14, 15, 16: rst_val = `DPR_RST_FRATED;
      default: rst_val = 32'h0000_0000;
    endcase
  endfunction

  assign wix = aph_q.addr[6:2];
  assign rix = haddr[6:2];

  // Bus capture, clamped writes and read mux; reads see a
  // write in its data phase so back-to-back access is coherent
  always_comb begin
    aph_d.valid = hsel & hready & htrans[1];
    aph_d.write = hwrite;
    aph_d.addr  = haddr[7:0];
    regs_d = regs_q;
    if (aph_q.valid && aph_q.write && aph_q.addr < `DPR_OFS_STAT) begin
      case (aph_q.addr)
        `DPR_OFS_KP: regs_d[wix] = clampv(hwdata, 32'h0, `DPR_KP_MAX); // R8
        `DPR_OFS_TI:  regs_d[wix] = clampv(hwdata, `DPR_TI_MIN,
                                           `DPR_TI_OFF); // R9
        `DPR_OFS_TD: regs_d[wix] = clampv(hwdata, 32'h0, `DPR_TD_MAX);
        `DPR_OFS_SDCAP, `DPR_OFS_PDCAP:
          regs_d[wix] = clampv(hwdata, `DPR_CAP_MIN,
                               `DPR_CAP_MAX); // R11 R16
        `DPR_OFS_TAU: regs_d[wix] = clampv(hwdata, `DPR_TAU_MIN,
                                           `DPR_TAU_MAX); // R2
        `DPR_OFS_VSTART, `DPR_OFS_U1, `DPR_OFS_U2, `DPR_OFS_U3:
          regs_d[wix] = clampv(hwdata, 32'h0, `DPR_VOLT_MAX); // R13
        `DPR_OFS_F1: regs_d[wix] = clampv(hwdata, 32'h0, regs_q[15]); // R14
        `DPR_OFS_F2:  regs_d[wix] = clampv(hwdata, regs_q[14],
                                           regs_q[16]);
        `DPR_OFS_F3:  regs_d[wix] = clampv(hwdata, regs_q[15],
                                           `DPR_FREQ_TOP); // R15
        default:      regs_d[wix] = hwdata;
      endcase
    end
    if (haddr[7:0] < `DPR_OFS_STAT)
      rdata_d = regs_d[rix];
    else if (haddr[7:0] == `DPR_OFS_STAT)
      rdata_d = {freq_q, 13'h0, lim_q, 2'(state_q)};
    else if (haddr[7:0] == `DPR_OFS_VOLT)
      rdata_d = {16'h0, volt_q};
    else
      rdata_d = 32'h0;
  end

  // Zero-wait slave; responses are always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q     <= '0;
      rdata_q   <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      for (int i = 0; i < `DPR_NREG_RW; i++)
        regs_q[i] <= rst_val(i);
    end else if (ce) begin
      aph_q     <= aph_d;
      rdata_q   <= rdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      regs_q    <= regs_d;
    end
  end
  assign hrdata = rdata_q;

  // ****************************************************************
  // Limit pin synchronisers and sample tick
  // ****************************************************************
  logic [1:0] cur_sq, volt_sq;
  logic [16:0] tick_q, tick_d;
  logic        tick;
  always_comb begin
    tick   = (tick_q == 17'(SAMPLE_CYC - 1));
    tick_d = tick ? 17'h0 : tick_q + 17'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_sq  <= 2'b00;
      volt_sq <= 2'b00;
      tick_q  <= 17'h0;
    end else if (ce) begin
      cur_sq  <= {cur_sq[0], cur_lim_pin};
      volt_sq <= {volt_sq[0], volt_lim_pin};
      tick_q  <= tick_d;
    end
  end

  // ****************************************************************
  // Regulator datapath
  // ****************************************************************
  logic [3:0]         cfg;
  logic               closed, spd_mode;
  logic [31:0]        tau, cap;
  logic [31:0]        alpha;
  logic signed [31:0] fbf_q, fbf_d, ferr;
  logic signed [47:0] fstep;
  logic signed [31:0] err, err_prev_q, err_prev_d, p_term, d_raw;
  logic signed [31:0] d_term, dlim, i_inc, integ_q, integ_d, u;
  logic signed [31:0] fmin, fmax, uc;
  logic               inv, aw_en, run;

  always_comb begin
    cfg      = regs_q[0][`DPR_CTL_CFG_LSB +: 4];
    inv      = regs_q[0][`DPR_CTL_INV];
    aw_en    = regs_q[0][`DPR_CTL_AW];
    run      = regs_q[0][`DPR_CTL_RUN];
    spd_mode = (cfg == `DPR_CFG_SPEED);
    closed   = spd_mode | (cfg == `DPR_CFG_PROC);
    // Speed tau and cap only apply in speed configuration
    tau = spd_mode ? regs_q[6] : `DPR_PROC_TAU; // R7 R2
    cap = spd_mode ? regs_q[4] : regs_q[5]; // R1 R7
    // Coefficient Ts/(tau+Ts) in Q16; divider is slow but has a
    // whole sample period to settle
    alpha = (32'(`DPR_TS_US) << 16) /
            (tau * 32'd1000 + 32'(`DPR_TS_US)); // R17
    ferr  = $signed({16'h0, meas.fb_val} << 8) - fbf_q;
    fstep = 48'(ferr) * $signed({16'h0, alpha});
    fbf_d = fbf_q + 32'(fstep >>> 16); // R17
    err = $signed({16'h0, meas.ref_val}) - (fbf_q >>> 8);
    if (inv)
      err = -err; // R4
    // Positive error raises frequency in normal mode
    p_term = ($signed(regs_q[1]) * err) / 32'sd1000; // R3 R8
    // Derivative on error change only; Td counts samples of 1 ms
    d_raw = ($signed(regs_q[1]) * $signed(regs_q[3]) *
             (err - err_prev_q)) / 32'sd1000; // R10
    dlim = ((p_term < 0 ? -p_term : p_term) *
            $signed(cap)) / 32'sd10; // R11 R16
    if (d_raw > dlim)
      d_term = dlim; // R1
    else if (d_raw < -dlim)
      d_term = -dlim; // R1
    else
      d_term = d_raw;
    i_inc = (regs_q[2] >= `DPR_TI_OFF) ? 32'sh0 :
            (p_term * 32'sd100) / $signed(regs_q[2]); // R9
    u    = integ_q + p_term + d_term;
    fmin = $signed(regs_q[8]);
    fmax = $signed(regs_q[9]);
    if (!closed)
      u = $signed({16'h0, meas.ref_val});
    uc = (u < fmin) ? fmin : ((u > fmax) ? fmax : u);
    lim_d = (u != uc) | cur_sq[1] | volt_sq[1];
    err_prev_d = err;
    integ_d = integ_q + i_inc;
    if (aw_en && lim_d)
      integ_d = $signed({16'h0, freq_q}); // R5
  end

  // Run-up then regulation
  always_comb begin
    state_d = state_q;
    freq_d  = freq_q;
    case (state_q)
      dpr_pkg::ST_IDLE: begin
        freq_d = 16'h0;
        if (run)
          state_d = dpr_pkg::ST_RAMP; // R6
      end
      dpr_pkg::ST_RAMP: begin
        if (!run)
          state_d = dpr_pkg::ST_IDLE;
        else if (freq_q >= regs_q[7][15:0])
          state_d = dpr_pkg::ST_LOOP; // R6
        else if (!cur_sq[1])
          freq_d = freq_q + `DPR_RAMP_STEP; // R6
      end
      dpr_pkg::ST_LOOP: begin
        if (!run)
          state_d = dpr_pkg::ST_IDLE;
        else
          freq_d = uc[15:0];
      end
      default: state_d = dpr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= dpr_pkg::ST_IDLE;
      freq_q     <= 16'h0;
      fbf_q      <= 32'sh0;
      err_prev_q <= 32'sh0;
      integ_q    <= 32'sh0;
      lim_q      <= 1'b0;
      running    <= 1'b0;
    end else if (ce && tick) begin
      running    <= (state_d == dpr_pkg::ST_LOOP);
      state_q    <= state_d;
      freq_q     <= freq_d;
      fbf_q      <= fbf_d;
      err_prev_q <= err_prev_d;
      lim_q      <= lim_d;
      if (state_q == dpr_pkg::ST_RAMP)
        integ_q <= $signed({16'h0, freq_q}); // R6
      else if (state_q == dpr_pkg::ST_LOOP)
        integ_q <= integ_d;
    end
  end

  // ****************************************************************
  // Voltage versus frequency curve
  // ****************************************************************
  logic [31:0] fa, fb, va, vb, vi, f;
  logic        special;
  always_comb begin
    special = (regs_q[0][`DPR_CTL_TQ_LSB +: 4] == `DPR_TQ_SPECIAL);
    f  = {16'h0, freq_q};
    fa = 32'h0;
    va = regs_q[10]; // R12
    fb = regs_q[16];
    vb = regs_q[13];
    if (special) begin
      if (f >= regs_q[14]) begin
        fa = regs_q[14];
        va = regs_q[11];
        fb = regs_q[15];
        vb = regs_q[12];
      end
      if (f >= regs_q[15]) begin
        fa = regs_q[15];
        va = regs_q[12];
        fb = regs_q[16];
        vb = regs_q[13];
      end
      if (f < regs_q[14]) begin
        fb = regs_q[14];
        vb = regs_q[11];
      end
    end
    // Beyond the top point the last voltage is held
    if (f >= fb || fb == fa)
      vi = vb; // R18
    else if (vb >= va)
      vi = va + ((vb - va) * (f - fa)) / (fb - fa); // R18
    else
      vi = va - ((va - vb) * (f - fa)) / (fb - fa); // R18
    volt_d = vi[15:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      volt_q <= 16'h0;
    else if (ce)
      volt_q <= volt_d;
  end

  assign freq_cmd = freq_q;
  assign volt_cmd = volt_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_ramp_done;
    ce && tick && state_q == dpr_pkg::ST_RAMP && run &&
      freq_q >= regs_q[7][15:0];
  endsequence
  a_kp_range: assert property (regs_q[1] <= `DPR_KP_MAX) // R8
    else $error("P gain out of range");
  a_tau_range: assert property (regs_q[6] >= `DPR_TAU_MIN && // R2
      regs_q[6] <= `DPR_TAU_MAX)
    else $error("Filter tau out of range");
  a_cap_range: assert property (regs_q[4] >= `DPR_CAP_MIN && // R11 R16
      regs_q[4] <= `DPR_CAP_MAX && regs_q[5] >= `DPR_CAP_MIN &&
      regs_q[5] <= `DPR_CAP_MAX)
    else $error("Derivative cap out of range");
  a_curve_order: assert property (regs_q[14] <= regs_q[15]) // R14
    else $error("First curve point above second");
  a_curve_top: assert property (regs_q[15] <= regs_q[16] && // R15
      regs_q[16] <= `DPR_FREQ_TOP)
    else $error("Third curve point out of range");
  a_loop_entry: assert property (s_ramp_done |=> // R6
      state_q == dpr_pkg::ST_LOOP && integ_q == $past(freq_q))
    else $error("Run-up did not hand over to regulation");
  a_awu_reload: assert property (ce && tick && // R5
      state_q == dpr_pkg::ST_LOOP && run && aw_en && lim_d |=>
      integ_q == $past(freq_q))
    else $error("Integrator not reloaded at limit");
  a_dir_normal: assert property (!inv && // R3
      regs_q[1] >= 32'd1000 &&
      $signed({16'h0, meas.ref_val}) > (fbf_q >>> 8) |-> p_term > 0)
    else $error("Normal mode correction has wrong sign");
  a_dir_inverse: assert property (inv && // R4
      regs_q[1] >= 32'd1000 &&
      $signed({16'h0, meas.ref_val}) > (fbf_q >>> 8) |-> p_term < 0)
    else $error("Inverse mode correction has wrong sign");
  a_d_off: assert property (regs_q[3] == 32'h0 |-> d_term == 0) // R10
    else $error("Derivative active with zero time");
  a_curve_hold: assert property (ce && special && // R18
      f >= regs_q[16] |=> volt_q == $past(regs_q[13][15:0]))
    else $error("Voltage not held past top point");
endmodule // dpr_regulator

// *** test/dpr_drive_model.sv ***
// ****************************************
// Inverter stage and feedback transmitter
// ****************************************
module dpr_drive_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // From regulator and bench
  input  wire logic [15:0] freq_cmd,
  input  wire logic        lim_req,
  // Back to regulator
  output logic [15:0]      fb_val,
  output logic             cur_lim_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Motor slews one step a cycle, so feedback lags the command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_val      <= 16'h0000;
      cur_lim_pin <= 1'b0;
    end else begin
      cur_lim_pin <= lim_req; // Stage reports limit a cycle late
      if (fb_val < freq_cmd)
        fb_val <= fb_val + 16'h0001;
      else if (fb_val > freq_cmd)
        fb_val <= fb_val - 16'h0001;
    end
  end
endmodule // dpr_drive_model

// *** test/drive_pid_regulator_vf_curve_tb.sv ***
`include "dpr_cfg.svh"
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end \
end
module drive_pid_regulator_vf_curve_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 8;
  // ****************************************
  // Signals and tables
  // ****************************************
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic               lim_req = 1'b0;
  logic [1:0]         htrans = 2'h0;
  logic [31:0]        haddr = 32'h0000_0000;
  logic [31:0]        hwdata = 32'h0000_0000;
  logic [15:0]        ref_v = 16'h0000;
  logic               hreadyout, hresp, running, cur_lim_pin;
  logic [31:0]        hrdata, rd;
  logic [15:0]        freq_cmd, volt_cmd, fb_val, f0, fp, fe;
  dpr_pkg::dpr_meas_s meas;
  int                 fail_count = 0;
  int                 n_tests = 0;
  int                 seed = 52397;
  int                 k, f;
  logic [31:0] rst_v [17] = '{`DPR_RST_CTRL, `DPR_RST_KP, `DPR_RST_TI,
    32'h0000_0000, `DPR_CAP_MIN, `DPR_CAP_MIN, `DPR_RST_TAU,
    32'h0000_0000, `DPR_RST_FMIN, `DPR_RST_FMAX, 32'h0000_0000,
    `DPR_RST_VRATED, `DPR_RST_VRATED, `DPR_RST_VRATED,
    `DPR_RST_FRATED, `DPR_RST_FRATED, `DPR_RST_FRATED};
  // Out-of-range writes and a P gain write of 0, plus an unmapped and a read-only place
  logic [7:0]  cl_a [16] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h10, 8'h10,
    8'h14, 8'h14, 8'h18, 8'h18, 8'h2C, 8'h40, 8'h40, 8'h38, 8'h50, 8'h48};
  logic [31:0] cl_w [16] = '{32'h0000_07D0, 32'h0000_0000, 32'h0000_0064,
    32'h0003_0000, 32'h0000_000A, 32'h0000_1000, 32'h0000_0001,
    32'h0000_1000, 32'h0000_0005, 32'h0000_0900, 32'h0000_8000,
    32'h0000_4000, 32'h0000_0010, 32'h0000_1000, 32'h0000_1234,
    32'h0000_FFFF};
  logic [31:0] cl_e [16] = '{`DPR_KP_MAX, 32'h0000_0000, `DPR_TI_MIN,
    `DPR_TI_OFF, `DPR_CAP_MIN, `DPR_CAP_MAX, `DPR_CAP_MIN, `DPR_CAP_MAX,
    `DPR_TAU_MIN, `DPR_TAU_MAX, `DPR_VOLT_MAX, `DPR_FREQ_TOP,
    `DPR_RST_FRATED, `DPR_RST_FRATED, 32'h0000_0000, 32'h0000_0000};
  int cnr [5] = '{0, 100, 300, 401, 650};

  // Clock and feedback bundle
  always #4 hclk = ~hclk;
  assign meas = {ref_v, fb_val};

  dpr_regulator #(.SAMPLE_CYC(SC)) uut (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .meas(meas),
    .cur_lim_pin(cur_lim_pin), .volt_lim_pin(cur_lim_pin),
    .freq_cmd(freq_cmd), .volt_cmd(volt_cmd), .running(running));

  dpr_drive_model pm (
    .hclk(hclk), .hresetn(hresetn), .freq_cmd(freq_cmd),
    .lim_req(lim_req), .fb_val(fb_val), .cur_lim_pin(cur_lim_pin));

  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait for hready; a hang ends the run
  task automatic wait_rdy();
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask

  // One single word transfer, read data taken at the data edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e);
    bus(1'b1, a, d);
    bus(1'b0, a, 32'h0000_0000);
    `CHK("register readback", e, rd)
  endtask

  // Frequency moves only on ticks, so the bound is in ticks
  task automatic wait_freq(input logic [15:0] t);
    k = 0;
    while (freq_cmd !== t && k < 800 * SC) begin
      @(posedge hclk);
      k++;
    end
    `CHK("freq_cmd", t, freq_cmd)
  endtask

  // Curve: start 200 at 0, 1200 at 100, 1600 at 300, 4200 at 400
  function automatic logic [15:0] vexp(input int fr, input bit spc);
    int v;
    if (fr >= 400)
      v = 4200;
    else if (!spc || fr <= 100)
      v = 200 + 10 * fr;
    else if (fr <= 300)
      v = 1200 + 2 * (fr - 100);
    else
      v = 1600 + 26 * (fr - 300);
    return 16'(v);
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 17; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0000_0000);
      `CHK("reset value", rst_v[i], rd)
    end
    for (int i = 0; i < 16; i++) begin
      wr_rd(cl_a[i], cl_w[i], cl_e[i]);
    end
    for (int i = 0; i < 4; i++) begin
      f = {$random(seed)} % 1001;
      wr_rd(`DPR_OFS_KP, 32'(f), 32'(f));
    end
    // Speed loop: open-loop run-up, stall at current limit
    wr_rd(`DPR_OFS_TAU, `DPR_TAU_MIN, `DPR_TAU_MIN);
    wr_rd(`DPR_OFS_KP, `DPR_KP_MAX, `DPR_KP_MAX);
    wr_rd(`DPR_OFS_TI, `DPR_TI_OFF, `DPR_TI_OFF);
    wr_rd(`DPR_OFS_ENTRY, 32'h0000_001E, 32'h0000_001E);
    ref_v <= 16'h012C;
    wr_rd(`DPR_OFS_CTRL, 32'h0000_0061, 32'h0000_0061);
    wait_freq(16'h000A);
    lim_req <= 1'b1;
    repeat (4) @(posedge hclk);
    f0 = freq_cmd;
    repeat (5 * SC) @(posedge hclk);
    `CHK("held ramp", f0, freq_cmd)
    lim_req <= 1'b0;
    k = 0;
    while (running !== 1'b1 && k < 100 * SC) begin
      fp = freq_cmd;
      @(posedge hclk);
      k++;
      if (running !== 1'b1 && freq_cmd !== fp)
        `CHK("ramp step", fp + 16'h0001, freq_cmd)
    end
    `CHK("entry frequency", 16'h001E, fp)
    // Direction of correction, normal then inverse
    repeat (20 * SC) @(posedge hclk);
    `CHK("normal rise", 1'b1, freq_cmd > 16'h001E)
    f0 = freq_cmd;
    bus(1'b1, `DPR_OFS_CTRL, 32'h0000_0071);
    repeat (20 * SC) @(posedge hclk);
    `CHK("inverse fall", 1'b1, freq_cmd < f0)
    // Integrator held at the frequency limit must unwind at once
    bus(1'b1, `DPR_OFS_FMAX, 32'h0000_0064);
    bus(1'b1, `DPR_OFS_TI, `DPR_TI_MIN);
    bus(1'b1, `DPR_OFS_CTRL, 32'h0000_0061);
    repeat (60 * SC) @(posedge hclk);
    `CHK("freq at limit", 16'h0064, freq_cmd)
    ref_v <= 16'h0000;
    repeat (3 * SC) @(posedge hclk);
    `CHK("unwound", 1'b1, freq_cmd < 16'h0064)
    // Voltage curve, special then plain, open loop follows reference
    bus(1'b1, `DPR_OFS_FMAX, `DPR_RST_FMAX);
    bus(1'b1, `DPR_OFS_VSTART, 32'h0000_00C8);
    bus(1'b1, `DPR_OFS_F1, 32'h0000_0064);
    bus(1'b1, `DPR_OFS_F2, 32'h0000_012C);
    bus(1'b1, `DPR_OFS_F3, 32'h0000_0190);
    bus(1'b1, `DPR_OFS_U1, 32'h0000_04B0);
    bus(1'b1, `DPR_OFS_U2, 32'h0000_0640);
    bus(1'b1, `DPR_OFS_U3, 32'h0000_1068);
    bus(1'b1, `DPR_OFS_CTRL, 32'h0000_0840);
    for (int i = 0; i < 12; i++) begin
      if (i == 9)
        bus(1'b1, `DPR_OFS_CTRL, 32'h0000_0040);
      f = (i < 5) ? cnr[i] : {$random(seed)} % 700;
      fe = 16'((f > 500) ? 500 : f);
      ref_v <= 16'(f);
      wait_freq(fe);
      repeat (2) @(posedge hclk);
      `CHK("volt_cmd", vexp(fe, i < 9), volt_cmd)
      bus(1'b0, `DPR_OFS_VOLT, 32'h0000_0000);
      `CHK("volt read", {16'h0000, vexp(fe, i < 9)}, rd)
    end
    conclude();
  end
endmodule // drive_pid_regulator_vf_curve_tb
